// ### rtl/apc_cnt_if.sv
// Carrier between the period control logic and the down-counter core.
`timescale 1ns/1ps
interface apc_cnt_if;
   logic load;
   logic [11:0] load_value;
   logic [11:0] count;
   logic zero;

   // Control side steers the counter and watches its value.
   modport ctrl (
      output load,
      output load_value,
      input count,
      input zero
   );

   // Counter side.
   modport core (
      input load,
      input load_value,
      output count,
      output zero
   );
endinterface : apc_cnt_if

// ### rtl/apc_period_counter.sv
// Twelve-bit down-counter that times one output period.
`timescale 1ns/1ps
module apc_period_counter
   import apc_pkg::*;
(
   // Clock, enable and reset.
   input wire logic ref_clk,
   input wire logic clk_en,
   input wire logic rst_n,
   // Control link.
   apc_cnt_if.core cnt
);

   logic [11:0] count_q;
   logic [11:0] count_d;

   // A load wins over the decrement; otherwise count down once per cycle.
   always_comb begin
      if (cnt.load) begin
         count_d = cnt.load_value;
      end else begin
         count_d = count_q - 12'h001;
      end
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= APC_COUNT_RESET;
      end else if (clk_en) begin
         count_q <= count_d;
      end
   end

   assign cnt.count = count_q;
   assign cnt.zero = (count_q == 12'h000);

endmodule : apc_period_counter

// ### rtl/apc_period_sync_counter.sv
// Output period counter with latch, restart and start-value realignment.
// How it works
// - Period start loads rate-derived count, 511 to 4095.
// - Latch request bit captures current counter value.
// - Latch request bit self-clears one cycle later.
// - Captured value readable as 16-bit register.
// - Restart bit abandons period, starts new one.
// - Written start value seeds the next period started at zero.
// - Start value written low byte, then high.
// - Captured value stays readable next output cycle.
// - Restart bit self-clears one cycle later.
// - Ready output low 64 cycles per period while configuration bit zero is clear.
// - Twelve-bit counter decrements every core clock while the clock enable is high.
// - Configuration bits five to four select rate.
`timescale 1ns/1ps
module apc_period_sync_counter
   import apc_pkg::*;
(
   // Clock, enable and reset.
   input wire logic ref_clk,
   input wire logic clk_en,
   input wire logic rst_n,
   // Register port from the serial front end, already on ref_clk.
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [15:0] reg_rdata,
   // Period outputs.
   output logic sample_ready_n,
   output logic period_start,
   output logic clkout_select
);

   // Reset release synchroniser; the pin drops at once, rises after two clock-enabled edges.
   logic [1:0] rst_sync_q;
   logic rst_n_sync;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'b00;
      end else if (clk_en) begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n_sync = rst_sync_q[1];

   // Counter core and its carrier.
   apc_cnt_if cnt_link ();

   apc_period_counter u_counter (
      .ref_clk (ref_clk),
      .clk_en (clk_en),
      .rst_n (rst_n_sync),
      .cnt (cnt_link.core)
   );

   // Register state.
   logic [7:0] config_q;
   logic [7:0] config_d;
   logic [7:0] align_ctrl_q;
   logic [7:0] align_ctrl_d;
   logic [15:0] latched_q;
   logic [15:0] latched_d;
   logic [7:0] start_low_q;
   logic [7:0] start_low_d;
   logic [7:0] start_high_q;
   logic [7:0] start_high_d;
   logic seed_pending_q;
   logic seed_pending_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;

   // Period state.
   logic [6:0] ready_cnt_q;
   logic [6:0] ready_cnt_d;
   logic ready_n_q;
   logic ready_n_d;
   logic start_pulse_q;
   logic start_pulse_d;

   // Decoded events.
   logic wr_config;
   logic wr_ctrl;
   logic wr_start_low;
   logic wr_start_high;
   logic restart_now;
   logic latch_now;
   logic new_period;
   logic use_seed;
   logic ready_mode;
   logic [1:0] rate_sel;
   logic [11:0] rate_count;
   logic [11:0] seed_value;

   assign wr_config = reg_wr_en && (reg_addr == APC_OFF_CONFIG);
   assign wr_ctrl = reg_wr_en && (reg_addr == APC_OFF_ALIGN_CTRL);
   assign wr_start_low = reg_wr_en && (reg_addr == APC_OFF_START_LOW);
   assign wr_start_high = reg_wr_en && (reg_addr == APC_OFF_START_HIGH);

   // Command bits act during the one cycle they read as set.
   assign restart_now = align_ctrl_q[APC_CTRL_RESTART_BIT];
   assign latch_now = align_ctrl_q[APC_CTRL_LATCH_BIT];

   assign rate_sel = config_q[APC_CFG_RATE_MSB:APC_CFG_RATE_LSB];
   assign ready_mode = !config_q[APC_CFG_CLKOUT_BIT];
   assign seed_value = {start_high_q[3:0], start_low_q};

   // Rate setting to period start count.
   always_comb begin
      unique case (apc_rate_t'(rate_sel))
         APC_RATE_8K: rate_count = APC_START_COUNT_8K;
         APC_RATE_4K: rate_count = APC_START_COUNT_4K;
         APC_RATE_2K: rate_count = APC_START_COUNT_2K;
         APC_RATE_1K: rate_count = APC_START_COUNT_1K;
      endcase
   end

   // A period starts at zero or on restart; restart always takes the rate count.
   assign new_period = restart_now || cnt_link.zero;
   assign use_seed = seed_pending_q && !restart_now;
   assign cnt_link.load = new_period;
   assign cnt_link.load_value = use_seed ? seed_value : rate_count;

   // Register next-state logic.
   always_comb begin
      config_d = config_q;
      align_ctrl_d = APC_ALIGN_CTRL_RESET;
      latched_d = latched_q;
      start_low_d = start_low_q;
      start_high_d = start_high_q;
      seed_pending_d = seed_pending_q;
      if (wr_config) begin
         config_d = reg_wdata;
      end
      if (wr_ctrl) begin
         align_ctrl_d[APC_CTRL_RESTART_BIT] = reg_wdata[APC_CTRL_RESTART_BIT];
         align_ctrl_d[APC_CTRL_LATCH_BIT] = reg_wdata[APC_CTRL_LATCH_BIT];
      end
      // Captured value is held until the next latch, so it survives the next period.
      if (latch_now) begin
         latched_d = {4'h0, cnt_link.count};
      end
      if (wr_start_low) begin
         start_low_d = reg_wdata;
      end
      // Seed is consumed once; a high-byte write in the same cycle still wins.
      if (new_period && use_seed) begin
         seed_pending_d = 1'b0;
      end
      if (wr_start_high) begin
         start_high_d = {4'h0, reg_wdata[3:0]};
         seed_pending_d = 1'b1;
      end
   end

   // Read data, one cycle after the read strobe; unmapped offsets read zero.
   always_comb begin
      rdata_d = rdata_q;
      if (reg_rd_en) begin
         unique case (reg_addr)
            APC_OFF_CONFIG: rdata_d = {8'h00, config_q};
            APC_OFF_ALIGN_CTRL: rdata_d = {8'h00, align_ctrl_q};
            APC_OFF_LATCHED_COUNT: rdata_d = latched_q;
            APC_OFF_START_LOW: rdata_d = {8'h00, start_low_q};
            APC_OFF_START_HIGH: rdata_d = {8'h00, start_high_q};
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         config_q <= APC_CONFIG_RESET;
         align_ctrl_q <= APC_ALIGN_CTRL_RESET;
         latched_q <= APC_LATCHED_RESET;
         start_low_q <= APC_START_BYTE_RESET;
         start_high_q <= APC_START_BYTE_RESET;
         seed_pending_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else if (clk_en) begin
         config_q <= config_d;
         align_ctrl_q <= align_ctrl_d;
         latched_q <= latched_d;
         start_low_q <= start_low_d;
         start_high_q <= start_high_d;
         seed_pending_q <= seed_pending_d;
         rdata_q <= rdata_d;
      end
   end

   // Ready pulse: reloaded at every period start so a restart never shortens it.
   always_comb begin
      if (new_period) begin
         ready_cnt_d = APC_READY_CYCLES;
      end else if (ready_cnt_q != 7'h00) begin
         ready_cnt_d = ready_cnt_q - 7'h01;
      end else begin
         ready_cnt_d = ready_cnt_q;
      end
      ready_n_d = !(ready_mode && (ready_cnt_d != 7'h00));
      start_pulse_d = new_period;
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         ready_cnt_q <= 7'h00;
         ready_n_q <= 1'b1;
         start_pulse_q <= 1'b0;
      end else if (clk_en) begin
         ready_cnt_q <= ready_cnt_d;
         ready_n_q <= ready_n_d;
         start_pulse_q <= start_pulse_d;
      end
   end

   // Outputs all come from flip-flops.
   assign reg_rdata = rdata_q;
   assign sample_ready_n = ready_n_q;
   assign period_start = start_pulse_q;
   assign clkout_select = config_q[APC_CFG_CLKOUT_BIT];

endmodule : apc_period_sync_counter

// ### rtl/apc_pkg.sv
// Shared constants for the period synchronisation counter block.
package apc_pkg;

   // Register offsets on the internal register port.
   localparam logic [4:0] APC_OFF_CONFIG = 5'h01;
   localparam logic [4:0] APC_OFF_ALIGN_CTRL = 5'h02;
   localparam logic [4:0] APC_OFF_LATCHED_COUNT = 5'h03;
   localparam logic [4:0] APC_OFF_START_LOW = 5'h04;
   localparam logic [4:0] APC_OFF_START_HIGH = 5'h05;

   // Field positions.
   localparam int APC_CFG_CLKOUT_BIT = 0;
   localparam int APC_CFG_RATE_LSB = 4;
   localparam int APC_CFG_RATE_MSB = 5;
   localparam int APC_CTRL_RESTART_BIT = 0;
   localparam int APC_CTRL_LATCH_BIT = 1;

   // Reset values.
   localparam logic [7:0] APC_CONFIG_RESET = 8'h00;
   localparam logic [7:0] APC_ALIGN_CTRL_RESET = 8'h00;
   localparam logic [11:0] APC_COUNT_RESET = 12'h000;
   localparam logic [15:0] APC_LATCHED_RESET = 16'h0000;
   localparam logic [7:0] APC_START_BYTE_RESET = 8'h00;

   // Period start counts per output rate setting (core clock / rate - 1).
   localparam logic [11:0] APC_START_COUNT_8K = 12'h01FF;
   localparam logic [11:0] APC_START_COUNT_4K = 12'h03FF;
   localparam logic [11:0] APC_START_COUNT_2K = 12'h07FF;
   localparam logic [11:0] APC_START_COUNT_1K = 12'h0FFF;

   // Length of the active-low ready pulse in core clock cycles.
   localparam logic [6:0] APC_READY_CYCLES = 7'h40;

   // Output rate settings.
   typedef enum logic [1:0] {
      APC_RATE_8K = 2'h0,
      APC_RATE_4K = 2'h1,
      APC_RATE_2K = 2'h2,
      APC_RATE_1K = 2'h3
   } apc_rate_t;

endpackage : apc_pkg

// ### tb/apc_checker.sv
// Port-level assertions for the period synchronisation counter.
`timescale 1ns/1ps
module apc_checker
   import apc_pkg::*;
(
   // Watched top ports.
   input wire logic ref_clk,
   input wire logic clk_en,
   input wire logic rst_n,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic sample_ready_n,
   input wire logic period_start,
   input wire logic clkout_select
);
   logic [6:0] age, age_q;
   logic seen_q;
   logic wa;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Cycles since the last period start; saturating so it never wraps into a false pulse.
   always_comb age = period_start ? 7'h00 : age_q;
   always_comb wa = reg_wr_en && reg_addr == APC_OFF_ALIGN_CTRL;
   // The ready check waits for a start seen in ready mode; it freezes with the block's clock enable.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         age_q <= 7'h00;
         seen_q <= 1'b0;
      end else if (clk_en) begin
         age_q <= (age >= 7'h40) ? age : age + 7'h01;
         seen_q <= !clkout_select && (seen_q || period_start);
      end
   end
   a_start_one_cycle: assert property (period_start |=> !period_start)
      else $error("period start pulse too long");
   a_ready_pulse_len: assert property (seen_q && !clkout_select |-> sample_ready_n == (age >= 7'h40))
      else $error("ready pulse length wrong");
   a_restart_reload: assert property (wa && reg_wdata[0] |-> ##2 period_start)
      else $error("restart did not begin a period");
   a_ctrl_self_clear: assert property (reg_rd_en && reg_addr == APC_OFF_ALIGN_CTRL |=>
      reg_rdata[1:0] == ($past(wa, 2) ? $past(reg_wdata[1:0], 2) : 2'b00))
      else $error("control bits did not self clear");
   a_unmapped_zero: assert property (reg_rd_en && (reg_addr == 5'h00 || reg_addr > 5'h05) |=> reg_rdata == 0)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (!reg_rd_en |=> $stable(reg_rdata))
      else $error("read data changed without read");
   a_latched_upper: assert property (reg_rd_en && reg_addr == APC_OFF_LATCHED_COUNT |=> reg_rdata[15:12] == 0)
      else $error("latched count upper bits set");
   a_clkout_follow: assert property (reg_wr_en && reg_addr == APC_OFF_CONFIG |->
      ##2 clkout_select == $past(reg_wdata[0], 2))
      else $error("clock out select wrong");
endmodule : apc_checker

// ### tb/apc_host_model.sv
// Host controller model driving the register port.
`timescale 1ns/1ps
module apc_host_model
   import apc_pkg::*;
#(parameter logic [4:0] KEY_OFF = 5'h1f)
(
   // Clock.
   input wire logic ref_clk,
   // Register port toward the block.
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [4:0] reg_addr,
   output logic [7:0] reg_wdata
);
   // Quiet at time zero.
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 8'h00;
   end
   // One strobe cycle per call, so calls in a row give adjacent requests.
   task automatic op(input logic w, input logic r, input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr_en <= w;
      reg_rd_en <= r;
      reg_addr <= a;
      reg_wdata <= d;
   endtask : op
   // Idle lines flip so a stale address is never mistaken for a live one.
   task automatic idle;
      op(1'b0, 1'b0, ~reg_addr, ~reg_wdata);
   endtask : idle
   // Correction for a lagging device against a reference count.
   function automatic logic [11:0] corr(input logic [11:0] cx, input logic [11:0] cy, input logic [11:0] c0);
      return (cy > cx) ? cx + c0 - cy : cx - cy;
   endfunction : corr
   // Unlock, low byte then high byte, relock; junk lands in unused high bits.
   task automatic load_start(input logic [11:0] v, input logic [3:0] junk);
      op(1'b1, 1'b0, KEY_OFF, 8'h9c);
      op(1'b1, 1'b0, APC_OFF_START_LOW, v[7:0]);
      op(1'b1, 1'b0, APC_OFF_START_HIGH, {junk, v[11:8]});
      op(1'b1, 1'b0, KEY_OFF, 8'hca);
   endtask : load_start
endmodule : apc_host_model

// ### tb/tb_top.sv
// Testbench top for the period synchronisation counter.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("BAD %0t %h/%h", $time, g, e); end end
module tb_top;
   import apc_pkg::*;
   logic ref_clk, clk_en, rst_n, reg_wr_en, reg_rd_en, period_start, sample_ready_n, clkout_select, rd_q;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic [11:0] s, v;
   logic [15:0] rq[$];
   int pq[$];
   int fail_count, total_checks, gap, j;
   // Free running core clock.
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   apc_period_sync_counter u_apc_period_sync_counter (.ref_clk, .clk_en, .rst_n, .reg_wr_en, .reg_rd_en,
      .reg_addr, .reg_wdata, .reg_rdata, .sample_ready_n, .period_start, .clkout_select);
   apc_host_model u_apc_host_model (.ref_clk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata);
   // Reads answer one cycle after the strobe; period gaps are counted edge to edge.
   always @(posedge ref_clk) begin
      if (rd_q) `CHK(reg_rdata, rq.pop_front())
      if (period_start && pq.size() > 0) `CHK(gap, pq.pop_front())
      rd_q <= reg_rd_en;
      gap <= period_start ? 1 : gap + 1;
   end
   task automatic rdx(input logic [4:0] a, input logic [15:0] e);
      u_apc_host_model.op(1'b0, 1'b1, a, 8'h00);
      rq.push_back(e);
   endtask : rdx
   // A period start that never comes counts as a mismatch.
   task automatic wait_ps;
      int k;
      for (k = 0; k < 5000 && period_start !== 1'b1; k++) @(posedge ref_clk);
      if (k == 5000) fail_count++;
   endtask : wait_ps
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report
   // Watchdog sized well above the longest sequence.
   initial begin
      #3_000_000;
      fail_count++;
      final_report();
   end
   // Main sequence.
   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      rd_q = 1'b0;
      gap = 0;
      j = $urandom(32'h6ce5_af01);
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      for (int a = 0; a < 8; a++) rdx(5'(a), 16'h0000);
      u_apc_host_model.idle();
      $display("reset values done");
      for (int r = 0; r < 4; r++) begin
         s = 12'((13'h0200 << r) - 13'h0001);
         j = $urandom_range(40);
         u_apc_host_model.op(1'b1, 1'b0, APC_OFF_CONFIG, 8'(r << 4));
         u_apc_host_model.op(1'b1, 1'b0, APC_OFF_ALIGN_CTRL, 8'h01);
         rdx(APC_OFF_ALIGN_CTRL, 16'h0001);
         repeat (2) u_apc_host_model.idle();
         // Three frozen cycles must not advance the counter.
         clk_en <= 1'b0;
         repeat (3) u_apc_host_model.idle();
         clk_en <= 1'b1;
         repeat (j) u_apc_host_model.idle();
         u_apc_host_model.op(1'b1, 1'b1, APC_OFF_ALIGN_CTRL, 8'h02);
         rq.push_back(16'h0000);
         rdx(APC_OFF_ALIGN_CTRL, 16'h0002);
         rdx(APC_OFF_LATCHED_COUNT, {4'h0, s - 12'(j) - 12'h003});
         u_apc_host_model.idle();
         wait_ps;
         @(posedge ref_clk);
         pq.push_back(int'(s) + 1);
         wait_ps;
      end
      $display("rates and latch done");
      v = u_apc_host_model.corr(12'(300 + $urandom_range(199)), 12'($urandom_range(99)), s);
      u_apc_host_model.load_start(v, 4'($urandom));
      rdx(APC_OFF_START_LOW, {8'h00, v[7:0]});
      rdx(APC_OFF_START_HIGH, {12'h000, v[11:8]});
      u_apc_host_model.op(1'b1, 1'b0, APC_OFF_CONFIG, 8'h31);
      rdx(APC_OFF_CONFIG, 16'h0031);
      u_apc_host_model.op(1'b1, 1'b0, APC_OFF_CONFIG, 8'h30);
      u_apc_host_model.idle();
      wait_ps;
      @(posedge ref_clk);
      pq.push_back(int'(v) + 1);
      pq.push_back(int'(s) + 1);
      wait_ps;
      @(posedge ref_clk);
      wait_ps;
      repeat (2) @(posedge ref_clk);
      // Re-check after correction: the latch lands five counts into the period.
      u_apc_host_model.op(1'b1, 1'b0, APC_OFF_ALIGN_CTRL, 8'h02);
      u_apc_host_model.idle();
      rdx(APC_OFF_LATCHED_COUNT, {4'h0, s - 12'h005});
      u_apc_host_model.idle();
      repeat (3) @(posedge ref_clk);
      $display("start value done");
      final_report();
   end
endmodule : tb_top
bind apc_period_sync_counter apc_checker u_apc_checker (.ref_clk, .clk_en, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr,
   .reg_wdata, .reg_rdata, .sample_ready_n, .period_start, .clkout_select);
